// File: logic/urx_pkg.sv
// Constants and types shared by the receive-side control block
package urx_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PURGE = 10'h043;
    localparam logic [9:0] IDX_LEVEL = 10'h044;
    localparam logic [9:0] IDX_WIDE = 10'h045;
    localparam logic [9:0] IDX_LATENCY = 10'h046;
    localparam logic [9:0] IDX_THRESH = 10'h047;
    localparam logic [9:0] IDX_DRIVER = 10'h060;
    localparam logic [9:0] IDX_SUSP_LVL = 10'h06a;
    localparam logic [9:0] IDX_SUSP_MODE = 10'h06b;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PURGE_RESET_BIT = 0;
    localparam int PURGE_OPEN_BIT = 1;
    localparam int PURGE_CLOSE_BIT = 2;
    localparam int SUSP_OVR_BIT = 15;
    localparam logic OPEN_RST = 1'b1;
    localparam logic CLOSE_RST = 1'b0;
    localparam logic [9:0] THRESH_RST = 10'h1c2;
    localparam logic [13:0] SUSP_PIN_MASK = 14'h3ccf;
    localparam logic [15:0] SUSP_MODE_MASK = 16'h8000;

    // ------------------------------------------------------------
    // Queue geometry and forwarding limits
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PTR_W = 9;
    localparam int COUNT_W = 10;
    localparam int DEPTH = 512;
    localparam logic [9:0] DEPTH_COUNT = 10'h200;
    localparam logic [9:0] PKT_CUSTOM = 10'h040;
    localparam logic [9:0] PKT_CLASS = 10'h03f;
    localparam logic [1:0] CHAR_TIMEOUT = 2'h3;
    localparam logic [23:0] BAUD_LIMIT = 24'h00a000;

    typedef enum logic [2:0] {
        FW_IDLE = 3'b001,
        FW_HOLD = 3'b010,
        FW_SEND = 3'b100
    } urx_fw_state_t;

endpackage : urx_pkg

// File: logic/urx_queue_if.sv
// Signals between the control logic and the receive queue
`timescale 1ns/10ps
interface urx_queue_if;
    logic push;
    logic [7:0] push_data;
    logic pop;
    logic [7:0] pop_data;
    logic flush;
    logic [9:0] count;
    logic full;
    logic empty;

    modport queue (input push, input push_data, input pop, input flush,
                   output pop_data, output count, output full, output empty);
    modport ctrl (output push, output push_data, output pop, output flush,
                  input pop_data, input count, input full, input empty);
endinterface : urx_queue_if

// File: logic/urx_rx_queue.sv
// Receive byte queue held in flip-flops with an occupancy count
`timescale 1ns/10ps
module urx_rx_queue (
    input wire logic pclk,       // core clock
    input wire logic presetn,    // async reset, active low
    urx_queue_if.queue q         // control side
);
    logic [7:0] mem [urx_pkg::DEPTH];
    logic [8:0] wr_ptr_reg;
    logic [8:0] rd_ptr_reg;
    logic [9:0] count_reg;
    logic [9:0] count_next;
    wire do_push;
    wire do_pop;

    // Flush beats a push in the same cycle: that byte is discarded too
    assign do_push = q.push & ~q.full & ~q.flush;
    assign do_pop = q.pop & ~q.empty & ~q.flush;
    assign q.full = (count_reg == urx_pkg::DEPTH_COUNT);
    assign q.empty = (count_reg == 10'h000);
    assign q.count = count_reg;
    assign q.pop_data = mem[rd_ptr_reg];
    assign count_next = q.flush ? 10'h000 :
                        (do_push & ~do_pop) ? count_reg + 10'h001 :
                        (do_pop & ~do_push) ? count_reg - 10'h001 : count_reg;

    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= q.push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= 9'h000;
            rd_ptr_reg <= 9'h000;
            count_reg <= 10'h000;
        end else begin
            wr_ptr_reg <= q.flush ? 9'h000 : wr_ptr_reg + {8'h00, do_push};
            rd_ptr_reg <= q.flush ? 9'h000 : rd_ptr_reg + {8'h00, do_pop};
            count_reg <= count_next;
        end
    end
endmodule : urx_rx_queue

// File: logic/urx_rx_ctrl.sv
// Receive queue control, forwarding policy and suspend pin levels behind APB
//
// Behaviour
// - Auto-close set: disabling receiver flushes queue
// - Auto-open set: enabling receiver flushes queue
// - Writing purge bit 0 flushes, self-clearing
// - Level register reports queue occupancy, bits 9:0
// - Wide-select bit 0 picks wide receive
// - Class driver below 40960 bps forces low latency
// - Without low latency, wait packet or timeout
// - Class driver packet limit is 63 bytes
// - Low latency forwards queue at once
// - Flow stop once fill reaches threshold
// - Driver-select bit 0 marks custom driver
// - Override drives pins to suspend levels
// - Override clear keeps pins during suspend
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module urx_rx_ctrl (
    input wire logic pclk,              // core clock, 25 MHz
    input wire logic presetn,           // async reset, active low
    input wire logic psel,              // APB select
    input wire logic penable,           // APB access phase
    input wire logic pwrite,            // APB direction
    input wire logic [11:0] paddr,      // APB byte address
    input wire logic [31:0] pwdata,     // APB write data
    output logic [31:0] prdata,         // APB read data
    output logic pready,                // APB ready
    output logic pslverr,               // APB error on unmapped address
    input wire logic rx_enable,         // port receiver enabled
    input wire logic rx_valid,          // received byte strobe
    input wire logic [7:0] rx_data,     // received byte
    input wire logic [23:0] baud_rate,  // selected baud rate in bps
    input wire logic char_tick,         // one pulse per character time
    input wire logic bulk_req,          // bulk-in request pulse
    output logic fwd_valid,             // forwarded byte strobe
    output logic [7:0] fwd_data,        // forwarded byte
    output logic fwd_end,               // end of forwarded packet
    output logic flow_stop,             // flow control request
    output logic rx_wide_mode,          // wide receive mode
    output logic low_latency,           // low latency in force
    output logic custom_driver,         // custom host driver in use
    input wire logic suspended,         // bus suspend state
    input wire logic [13:0] func_pins,  // normal pin levels
    output logic [13:0] pin_level       // levels driven on the pins
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic auto_open_reg;
    logic auto_close_reg;
    logic flush_reg;
    logic wide_reg;
    logic latency_reg;
    logic latency_next;
    logic [9:0] thresh_reg;
    logic driver_reg;
    logic [13:0] susp_lvl_reg;
    logic susp_ovr_reg;
    logic rx_en_d_reg;
    logic flow_reg;
    logic [13:0] pin_reg;
    urx_pkg::urx_fw_state_t fw_state_reg;
    urx_pkg::urx_fw_state_t fw_state_next;
    logic [9:0] send_left_reg;
    logic [1:0] tick_cnt_reg;
    logic fwd_valid_reg;
    logic [7:0] fwd_data_reg;
    logic fwd_end_reg;

    urx_queue_if qi ();

    urx_rx_queue u_queue (
        .pclk(pclk),
        .presetn(presetn),
        .q(qi.queue)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup_phase = psel & ~penable;
    wire wr_en = psel & penable & pwrite & pready_reg;
    wire [9:0] idx = paddr[11:2];
    wire hit_purge = (idx == urx_pkg::IDX_PURGE);
    wire hit_level = (idx == urx_pkg::IDX_LEVEL);
    wire hit_wide = (idx == urx_pkg::IDX_WIDE);
    wire hit_latency = (idx == urx_pkg::IDX_LATENCY);
    wire hit_thresh = (idx == urx_pkg::IDX_THRESH);
    wire hit_driver = (idx == urx_pkg::IDX_DRIVER);
    wire hit_susp_lvl = (idx == urx_pkg::IDX_SUSP_LVL);
    wire hit_susp_mode = (idx == urx_pkg::IDX_SUSP_MODE);
    wire hit_any = hit_purge | hit_level | hit_wide | hit_latency | hit_thresh
                   | hit_driver | hit_susp_lvl | hit_susp_mode;

    // Write-only registers read as zero
    // level readback
    wire [31:0] rd_word = hit_level ? {22'h000000, qi.count} :
                     hit_wide ? {31'h00000000, wide_reg} :
                     hit_latency ? {31'h00000000, latency_reg} :
                     hit_thresh ? {22'h000000, thresh_reg} :
                     hit_susp_lvl ? {18'h00000, susp_lvl_reg} :
                     hit_susp_mode ? {16'h0000, susp_ovr_reg, 15'h0000} : 32'h00000000;

    // Answer is prepared in the setup cycle so the access phase never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase & ~hit_any;
            prdata_reg <= (setup_phase & ~pwrite) ? rd_word : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Flush sources
    // ------------------------------------------------------------
    wire rx_en_rise = rx_enable & ~rx_en_d_reg;
    wire rx_en_fall = ~rx_enable & rx_en_d_reg;
    wire flush_req = (rx_en_fall & auto_close_reg) | (rx_en_rise & auto_open_reg)
                       | (wr_en & hit_purge & pwdata[urx_pkg::PURGE_RESET_BIT]);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    wire auto_latency;

    assign auto_latency = ~driver_reg & (baud_rate < urx_pkg::BAUD_LIMIT);
    assign latency_next = auto_latency ? 1'b1 :
                          (wr_en & hit_latency) ? pwdata[0] : latency_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_open_reg <= urx_pkg::OPEN_RST;
            auto_close_reg <= urx_pkg::CLOSE_RST;
            wide_reg <= 1'b0;
            latency_reg <= 1'b0;
            thresh_reg <= urx_pkg::THRESH_RST;
            driver_reg <= 1'b0;
            susp_lvl_reg <= 14'h0000;
            susp_ovr_reg <= 1'b0;
        end else begin
            if (wr_en & hit_purge) begin
                auto_open_reg <= pwdata[urx_pkg::PURGE_OPEN_BIT];
                auto_close_reg <= pwdata[urx_pkg::PURGE_CLOSE_BIT];
            end
            if (wr_en & hit_wide) begin
                wide_reg <= pwdata[0];
            end
            latency_reg <= latency_next;
            if (wr_en & hit_thresh) begin
                thresh_reg <= pwdata[9:0];
            end
            if (wr_en & hit_driver) begin
                driver_reg <= pwdata[0];
            end
            if (wr_en & hit_susp_lvl) begin
                susp_lvl_reg <= pwdata[13:0] & urx_pkg::SUSP_PIN_MASK;
            end
            if (wr_en & hit_susp_mode) begin
                susp_ovr_reg <= pwdata[urx_pkg::SUSP_OVR_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Queue side: flush pulse, level watch
    // ------------------------------------------------------------
    wire flow_next;

    assign flow_next = ~flush_reg & (qi.count >= thresh_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_d_reg <= 1'b0;
            flush_reg <= 1'b0;
            flow_reg <= 1'b0;
        end else begin
            rx_en_d_reg <= rx_enable;
            flush_reg <= flush_req;
            flow_reg <= flow_next;
        end
    end

    // ------------------------------------------------------------
    // Forwarding to bulk-in
    // ------------------------------------------------------------
    // packet limit: custom driver or class driver
    wire [9:0] pkt_limit = driver_reg ? urx_pkg::PKT_CUSTOM : urx_pkg::PKT_CLASS;
    wire [9:0] entry_len = (qi.count < pkt_limit) ? qi.count : pkt_limit;
    wire in_idle = (fw_state_reg == urx_pkg::FW_IDLE);
    wire in_hold = (fw_state_reg == urx_pkg::FW_HOLD);
    wire in_send = (fw_state_reg == urx_pkg::FW_SEND);
    wire hold_full = qi.count >= pkt_limit;
    wire hold_timeout = (tick_cnt_reg == urx_pkg::CHAR_TIMEOUT);
    wire send_done = (send_left_reg == 10'h000) | qi.empty | flush_reg;

    assign qi.push = rx_valid;
    assign qi.push_data = rx_data;
    assign qi.flush = flush_reg;
    assign qi.pop = in_send & ~send_done;

    always_comb begin
        fw_state_next = fw_state_reg;
        case (fw_state_reg)
            urx_pkg::FW_IDLE: begin
                if (bulk_req) begin
                    fw_state_next = latency_reg ? urx_pkg::FW_SEND : urx_pkg::FW_HOLD;
                end
            end
            urx_pkg::FW_HOLD: begin
                if (latency_reg | hold_full | hold_timeout) begin
                    fw_state_next = urx_pkg::FW_SEND;
                end
            end
            urx_pkg::FW_SEND: begin
                if (send_done) begin
                    fw_state_next = urx_pkg::FW_IDLE;
                end
            end
            default: begin
                fw_state_next = urx_pkg::FW_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fw_state_reg <= urx_pkg::FW_IDLE;
            send_left_reg <= 10'h000;
            tick_cnt_reg <= 2'h0;
        end else begin
            fw_state_reg <= fw_state_next;
            if (~in_send & (fw_state_next == urx_pkg::FW_SEND)) begin
                send_left_reg <= entry_len;
            end else if (qi.pop) begin
                send_left_reg <= send_left_reg - 10'h001;
            end
            if (~in_hold) begin
                tick_cnt_reg <= 2'h0;
            end else if (char_tick & ~hold_timeout) begin
                tick_cnt_reg <= tick_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_valid_reg <= 1'b0;
            fwd_data_reg <= 8'h00;
            fwd_end_reg <= 1'b0;
        end else begin
            fwd_valid_reg <= qi.pop;
            fwd_data_reg <= qi.pop ? qi.pop_data : 8'h00;
            fwd_end_reg <= in_send & send_done;
        end
    end

    // ------------------------------------------------------------
    // Suspend pin levels
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reg <= 14'h0000;
        end else if (suspended & susp_ovr_reg) begin
            pin_reg <= susp_lvl_reg;
        end else if (~suspended) begin
            pin_reg <= func_pins & urx_pkg::SUSP_PIN_MASK;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign fwd_valid = fwd_valid_reg;
    assign fwd_data = fwd_data_reg;
    assign fwd_end = fwd_end_reg;
    assign flow_stop = flow_reg;
    assign rx_wide_mode = wide_reg;
    assign low_latency = latency_reg;
    assign custom_driver = driver_reg;
    assign pin_level = pin_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_close_flush_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_en_fall && auto_close_reg) |=> flush_reg ##1 (qi.count == 10'h000))
        else $error("disable with auto-close did not flush");
    chk_open_flush_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_en_rise && auto_open_reg) |=> flush_reg)
        else $error("enable with auto-open did not flush");
    chk_purge_self_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_purge && pwdata[urx_pkg::PURGE_RESET_BIT])
        |=> flush_reg ##1 (qi.count == 10'h000) && (!flush_reg || $past(rx_en_rise | rx_en_fall)))
        else $error("purge write did not flush");
    chk_level_read_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && hit_level)
        |=> (prdata == {22'h000000, $past(qi.count)}) && pready)
        else $error("level read returned wrong count");
    chk_wide_mode_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_wide) |=> (rx_wide_mode == $past(pwdata[0])))
        else $error("wide select not taken");
    chk_auto_latency_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!driver_reg && baud_rate < urx_pkg::BAUD_LIMIT) |=> low_latency)
        else $error("low latency not forced for slow class driver");
    chk_hold_until_full: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_hold && !latency_reg && !hold_full && !hold_timeout) |=> !in_send)
        else $error("data forwarded before packet or timeout");
    chk_class_pkt_limit: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_hold && !driver_reg && qi.count >= urx_pkg::PKT_CLASS) |=> in_send)
        else $error("class driver limit not honoured");
    chk_low_latency_send: assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_idle && bulk_req && latency_reg) |=> in_send)
        else $error("low latency request not forwarded at once");
    chk_flow_threshold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!flush_reg && qi.count >= thresh_reg) |=> flow_stop)
        else $error("flow stop missing at threshold");
    chk_flush_releases: assert property (
        @(posedge pclk) disable iff (!presetn)
        flush_reg |=> (qi.count == 10'h000) && !flow_stop)
        else $error("flush left level or flow stop");
    chk_suspend_levels: assert property (
        @(posedge pclk) disable iff (!presetn)
        (suspended && susp_ovr_reg) |=> (pin_level == $past(susp_lvl_reg)))
        else $error("suspend levels not driven");
    chk_suspend_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (suspended && !susp_ovr_reg) |=> $stable(pin_level))
        else $error("pins changed during suspend without override");

endmodule : urx_rx_ctrl

// File: tb/urx_host_model.sv
// Bulk-in host model: issues requests and gathers forwarded bytes
`timescale 1ns/10ps
module urx_host_model (
    input wire logic pclk,         // core clock
    input wire logic presetn,      // async reset, active low
    input wire logic go,           // start one bulk-in request
    output logic bulk_req,         // bulk-in request pulse
    input wire logic fwd_valid,    // forwarded byte strobe
    input wire logic [7:0] fwd_data, // forwarded byte
    input wire logic fwd_end,      // packet finished
    output int nbytes,             // bytes of the latest packet
    output logic [7:0] last_byte,  // latest byte taken
    output int nends               // packets finished so far
);
    // One request per go pulse; the count restarts with each request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bulk_req <= 1'b0;
            nbytes <= 0;
            last_byte <= 8'h00;
            nends <= 0;
        end else begin
            bulk_req <= go;
            if (go) begin
                nbytes <= 0;
            end else if (fwd_valid) begin
                nbytes <= nbytes + 1;
                last_byte <= fwd_data;
            end
            if (fwd_end) begin
                nends <= nends + 1;
            end
        end
    end
endmodule : urx_host_model

// File: tb/tb_uart_rx_fifo_and_suspend_ctrl.sv
// Self-checking bench for the receive control block
`timescale 1ns/10ps
module tb_uart_rx_fifo_and_suspend_ctrl;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_enable, rx_valid;
    logic char_tick, bulk_req, fwd_valid, fwd_end, flow_stop, rx_wide_mode, low_latency;
    logic custom_driver, suspended, go, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [7:0] rx_data, fwd_data, last_byte;
    logic [23:0] baud_rate;
    logic [13:0] func_pins, pin_level;
    int nbytes, nends, fail_count, n_checks, cyc;

    urx_rx_ctrl i_urx_rx_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_enable(rx_enable), .rx_valid(rx_valid), .rx_data(rx_data),
        .baud_rate(baud_rate), .char_tick(char_tick), .bulk_req(bulk_req),
        .fwd_valid(fwd_valid), .fwd_data(fwd_data), .fwd_end(fwd_end), .flow_stop(flow_stop),
        .rx_wide_mode(rx_wide_mode), .low_latency(low_latency), .custom_driver(custom_driver),
        .suspended(suspended), .func_pins(func_pins), .pin_level(pin_level));
    urx_host_model i_urx_host_model (.pclk(pclk), .presetn(presetn), .go(go),
        .bulk_req(bulk_req), .fwd_valid(fwd_valid), .fwd_data(fwd_data), .fwd_end(fwd_end),
        .nbytes(nbytes), .last_byte(last_byte), .nends(nends));

    always #20 pclk = ~pclk;
    // Whole run needs well under this many cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task push(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_data <= 8'(i + 1);
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
    endtask : push
    task bulk(input int nt);
        int e;
        e = nends;
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (int k = 0; k < nt && nends == e; k++) @(posedge pclk);
    endtask : bulk
    task flush();
        apb(1'b1, urx_pkg::IDX_PURGE, 32'h00000003);
        repeat (3) @(posedge pclk);
    endtask : flush

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset();
        apb(1'b0, urx_pkg::IDX_THRESH, 32'h0);
        chk(rdata, 32'h000001c2);
        apb(1'b0, urx_pkg::IDX_WIDE, 32'h0);
        chk(rdata, 32'h00000000);
        apb(1'b0, 10'h3ff, 32'h0);
        chk({31'h0, rerr}, 32'h00000001);
    endtask : t_reset
    task t_level();
        push(3);
        apb(1'b0, urx_pkg::IDX_LEVEL, 32'h0);
        chk(rdata, 32'h00000003);
        flush();
        apb(1'b0, urx_pkg::IDX_LEVEL, 32'h0);
        chk(rdata, 32'h00000000);
        push(1);
        apb(1'b0, urx_pkg::IDX_LEVEL, 32'h0);
        chk(rdata, 32'h00000001);
        apb(1'b1, urx_pkg::IDX_THRESH, 32'h00000002);
        chk({31'h0, flow_stop}, 32'h0);
        push(1);
        repeat (2) @(posedge pclk);
        chk({31'h0, flow_stop}, 32'h1);
        flush();
        chk({31'h0, flow_stop}, 32'h0);
        apb(1'b1, urx_pkg::IDX_THRESH, 32'h000001c2);
    endtask : t_level
    task t_auto(input logic en, input logic [31:0] mode, input logic [31:0] lvl);
        push(2);
        apb(1'b1, urx_pkg::IDX_PURGE, mode);
        push(2);
        rx_enable <= en;
        repeat (4) @(posedge pclk);
        apb(1'b0, urx_pkg::IDX_LEVEL, 32'h0);
        chk(rdata, lvl);
        flush();
    endtask : t_auto
    task t_forward();
        apb(1'b1, urx_pkg::IDX_LATENCY, 32'h00000001);
        push(2);
        bulk(20);
        chk(nbytes, 2);
        chk(last_byte, 8'h02);
        apb(1'b1, urx_pkg::IDX_LATENCY, 32'h00000000);
        baud_rate <= 24'h002580;
        repeat (2) @(posedge pclk);
        chk({31'h0, low_latency}, 32'h1);
        baud_rate <= 24'h01c200;
        // Auto low latency stays set until software clears it
        apb(1'b1, urx_pkg::IDX_LATENCY, 32'h00000000);
        apb(1'b1, urx_pkg::IDX_WIDE, 32'h00000001);
        @(posedge pclk);
        chk({31'h0, rx_wide_mode}, 32'h1);
        chk({31'h0, low_latency}, 32'h0);
        push(70);
        bulk(200);
        chk(nbytes, 63);
        chk(last_byte, 8'h3f);
        flush();
        // Custom driver flag goes in before any class command
        apb(1'b1, urx_pkg::IDX_DRIVER, 32'h00000001);
        @(posedge pclk);
        chk({31'h0, custom_driver}, 32'h1);
        push(65);
        bulk(200);
        chk(nbytes, 64);
        chk(last_byte, 8'h40);
        bulk(8);
        chk(nends, 3);
        repeat (3) begin
            @(posedge pclk);
            char_tick <= 1'b1;
            @(posedge pclk);
            char_tick <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        chk(nbytes, 1);
        chk(nends, 4);
    endtask : t_forward
    task t_suspend();
        apb(1'b1, urx_pkg::IDX_SUSP_LVL, 32'h00003ccf);
        apb(1'b1, urx_pkg::IDX_SUSP_MODE, 32'h00008000);
        suspended <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(pin_level, 14'h3ccf);
        func_pins <= 14'h0005;
        apb(1'b1, urx_pkg::IDX_SUSP_MODE, 32'h00000000);
        repeat (2) @(posedge pclk);
        chk(pin_level, 14'h3ccf);
        suspended <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(pin_level, 14'h0005);
    endtask : t_suspend

    initial begin
        {pclk, presetn, psel, penable, pwrite, rx_enable, rx_valid, char_tick} = 8'h00;
        {suspended, go, paddr, pwdata, rx_data, func_pins} = '0;
        baud_rate = 24'h01c200;
        fail_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_level();
        t_auto(1'b1, 32'h00000002, 32'h0);
        t_auto(1'b0, 32'h00000004, 32'h0);
        t_auto(1'b1, 32'h00000000, 32'h4);
        t_auto(1'b0, 32'h00000000, 32'h4);
        t_forward();
        t_suspend();
        close_out();
    end
endmodule : tb_uart_rx_fifo_and_suspend_ctrl
